// ==== xbd_pkg.sv ====
/*
 Constants, field layouts and types of the exchange / BCD / add datapath.
 Assumes an APB master with 32-bit data and byte addresses on PADDR.
*/
package xbd_pkg;
   localparam int APB_AW = 8;
   localparam int DW = 16;
   localparam int MEM_DEPTH_DEF = 256;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OPER = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ERRC = 8'h0c;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam logic [7:0] REG_MEM_PTR = 8'h18;
   localparam logic [7:0] REG_MEM_DATA = 8'h1c;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_WIDE = 2;
   localparam int CTRL_PULSE = 3;
   localparam int CTRL_INDEXED = 4;
   localparam int CTRL_HSWAP = 5;
   localparam int CTRL_EN = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam int OPER_A_LSB = 0;
   localparam int OPER_B_LSB = 8;
   localparam int OPER_D_LSB = 16;
   localparam logic [23:0] OPER_RST = 24'h000000;
   localparam int ST_ZERO = 0;
   localparam int ST_BORROW = 1;
   localparam int ST_CARRY = 2;
   localparam int ST_ERR_A = 3;
   localparam int ST_ERR_B = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_REJ = 2;
   localparam int IRQ_W = 3;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic [15:0] ERRC_RST = 16'h0000;
   localparam logic [15:0] ERR_RANGE_CODE = 16'h0e18;
   localparam logic [31:0] BCD16_MAX = 32'd9999;
   localparam logic [31:0] BCD32_MAX = 32'd99999999;
   localparam logic signed [32:0] ADD16_MAX = 33'sd32767;
   localparam logic signed [32:0] ADD16_MIN = -33'sd32768;
   localparam logic signed [32:0] ADD32_MAX = 33'sd2147483647;
   localparam logic signed [32:0] ADD32_MIN = -33'sd2147483648;
   typedef enum logic [1:0] {
      OP_EXCH = 2'b00,
      OP_BIN2BCD = 2'b01,
      OP_BCD2BIN = 2'b10,
      OP_ADD = 2'b11
   } xbd_op_t;
endpackage

// ==== xbd_exchange_bcd_add.sv ====
/*
 Exchange, binary/BCD conversion and signed addition datapath on a 16-bit word memory.
 Assumes an APB master on REF_CLK; software loads operands through the memory window.
*/
`timescale 1ns/10ps
module xbd_exchange_bcd_add #(
   parameter int MEM_DEPTH = xbd_pkg::MEM_DEPTH_DEF
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [xbd_pkg::APB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ
);
   import xbd_pkg::*;

   localparam int AW = $clog2(MEM_DEPTH);

   if (MEM_DEPTH < 4 || MEM_DEPTH > 256 || (1 << AW) != MEM_DEPTH)
   begin : g_bad_depth
      $error("MEM_DEPTH must be a power of two from 4 to 256");
   end

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++)
      begin
         m[8*i +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] to_bcd(input logic [31:0] v);
      logic [31:0] r;
      logic [31:0] rest;
      r = '0;
      rest = v;
      for (int i = 0; i < 8; i++)
      begin
         r[4*i +: 4] = 4'(rest % 32'd10);
         rest = rest / 32'd10;
      end
      return r;
   endfunction

   function automatic logic bcd_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         if (v[4*i +: 4] > 4'h9)
         begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [31:0] from_bcd(input logic [31:0] v);
      logic [31:0] acc;
      acc = '0;
      for (int i = 7; i >= 0; i--)
      begin
         acc = 32'(acc * 32'd10) + {28'h0000000, v[4*i +: 4]};
      end
      return acc;
   endfunction

   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic [23:0] oper, next_oper;
   logic [15:0] errc, next_errc;
   logic zero_result_flag, next_zero;
   logic borrow_flag, next_borrow;
   logic carry_flag, next_carry;
   logic operation_error_flag_a, next_err_a;
   logic operation_error_flag_b, next_err_b;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [IRQ_W-1:0] irq_mask, next_irq_mask;
   logic [AW-1:0] mem_ptr, next_mem_ptr;
   logic [31:0] next_prdata;
   logic next_irq;
   logic en_q, next_en_q;
   logic [DW-1:0] mem [MEM_DEPTH];
   logic we [5];
   logic [AW-1:0] wa [5];
   logic [DW-1:0] wd [5];

   logic apb_setup, apb_wr, addr_ok, apb_mem_wr;
   logic [31:0] wmask;
   xbd_op_t op;
   logic wide, indexed, hswap, en, fire, exec_go, reject;
   logic [AW-1:0] a1, a1p, a2, a2p, ad, adp;
   logic [DW-1:0] a_lo, a_hi, b_lo, b_hi;
   logic [31:0] va, vb, bcd_res, bin_res, bcd_src;
   logic bcd_range_bad, bcd_digit_bad, same_op;
   logic signed [32:0] sum;
   logic [31:0] sum_wrap;
   logic add_carry, add_borrow, add_zero;

   assign apb_setup = PSEL & ~PENABLE;
   assign apb_wr = PSEL & PENABLE & PWRITE;
   assign addr_ok = (PADDR[1:0] == 2'b00) && (PADDR <= REG_MEM_DATA);
   assign apb_mem_wr = apb_wr && (PADDR == REG_MEM_DATA);
   assign wmask = lane_mask(PSTRB);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~addr_ok;

   assign op = xbd_op_t'(ctrl[CTRL_OP_LSB +: 2]);
   assign wide = ctrl[CTRL_WIDE];
   assign indexed = ctrl[CTRL_INDEXED];
   assign hswap = ctrl[CTRL_HSWAP];
   assign en = ctrl[CTRL_EN];
   // Pulse form fires on the enable edge only, plain form every enabled cycle
   assign fire = ctrl[CTRL_PULSE] ? (en & ~en_q) : en;
   // A memory write from software holds execution off for one cycle; edge stays pending
   assign exec_go = fire & ~apb_mem_wr;
   assign reject = indexed & wide;

   assign a1 = AW'(oper[OPER_A_LSB +: 8]);
   assign a2 = AW'(oper[OPER_B_LSB +: 8]);
   assign ad = AW'(oper[OPER_D_LSB +: 8]);
   // High word at the next address; pairs wrap at the top of memory
   assign a1p = AW'(a1 + 1'b1);
   assign a2p = AW'(a2 + 1'b1);
   assign adp = AW'(ad + 1'b1);
   assign a_lo = mem[a1];
   assign a_hi = mem[a1p];
   assign b_lo = mem[a2];
   assign b_hi = mem[a2p];
   assign same_op = (a1 == a2);
   // Narrow operands are sign extended so both widths share one adder
   assign va = wide ? {a_hi, a_lo} : {{16{a_lo[15]}}, a_lo};
   assign vb = wide ? {b_hi, b_lo} : {{16{b_lo[15]}}, b_lo};

   assign bcd_range_bad = va[31] || (va > (wide ? BCD32_MAX : BCD16_MAX));
   assign bcd_res = to_bcd(va);
   assign bcd_src = wide ? {a_hi, a_lo} : {16'h0000, a_lo};
   assign bcd_digit_bad = ~bcd_ok(bcd_src);
   assign bin_res = from_bcd(bcd_src);

   assign sum = $signed({va[31], va}) + $signed({vb[31], vb});
   assign sum_wrap = sum[31:0];
   assign add_carry = wide ? (sum > ADD32_MAX) : (sum > ADD16_MAX);
   assign add_borrow = wide ? (sum < ADD32_MIN) : (sum < ADD16_MIN);
   assign add_zero = wide ? (sum_wrap == 32'h0) : (sum_wrap[15:0] == 16'h0);

   always_comb
   begin
      logic set_done, set_err, set_rej;
      logic [31:0] cur;
      set_done = 1'b0;
      set_err = 1'b0;
      set_rej = 1'b0;
      cur = '0;
      next_ctrl = ctrl;
      next_oper = oper;
      next_errc = errc;
      next_zero = zero_result_flag;
      next_borrow = borrow_flag;
      next_carry = carry_flag;
      next_err_a = operation_error_flag_a;
      next_err_b = operation_error_flag_b;
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      next_mem_ptr = mem_ptr;
      next_en_q = apb_mem_wr ? en_q : en;
      for (int i = 0; i < 5; i++)
      begin
         we[i] = 1'b0;
         wa[i] = '0;
         wd[i] = '0;
      end
      if (apb_wr)
      begin
         case (PADDR)
            REG_CTRL:
            begin
               cur = (32'(ctrl) & ~wmask) | (PWDATA & wmask);
               next_ctrl = cur[CTRL_W-1:0];
            end
            REG_OPER:
            begin
               cur = ({8'h00, oper} & ~wmask) | (PWDATA & wmask);
               next_oper = cur[23:0];
            end
            REG_STATUS:
            begin
               next_err_a = operation_error_flag_a & ~(PWDATA[ST_ERR_A] & PSTRB[0]);
               next_err_b = operation_error_flag_b & ~(PWDATA[ST_ERR_B] & PSTRB[0]);
            end
            REG_ERRC:
            begin
               cur = ({16'h0000, errc} & ~wmask) | (PWDATA & wmask);
               next_errc = cur[15:0];
            end
            REG_IRQ_STAT:
            begin
               next_irq_stat = irq_stat & ~(PWDATA[IRQ_W-1:0] & {IRQ_W{PSTRB[0]}});
            end
            REG_IRQ_MASK:
            begin
               if (PSTRB[0])
               begin
                  next_irq_mask = PWDATA[IRQ_W-1:0];
               end
            end
            REG_MEM_PTR:
            begin
               if (PSTRB[0])
               begin
                  next_mem_ptr = PWDATA[AW-1:0];
               end
            end
            REG_MEM_DATA:
            begin
               we[4] = 1'b1;
               wa[4] = mem_ptr;
               wd[4] = (mem[mem_ptr] & ~wmask[15:0]) | (PWDATA[15:0] & wmask[15:0]);
            end
            default:
            begin
               cur = '0;
            end
         endcase
      end
      if (exec_go)
      begin
         set_done = 1'b1;
         if (reject)
         begin
            set_rej = 1'b1;
         end
         else
         begin
            unique case (op)
               OP_EXCH:
               begin
                  if (same_op && hswap)
                  begin
                     we[0] = 1'b1;
                     wa[0] = a1;
                     wd[0] = a_hi;
                     we[1] = 1'b1;
                     wa[1] = a1p;
                     wd[1] = a_lo;
                  end
                  else
                  begin
                     we[0] = 1'b1;
                     wa[0] = a1;
                     wd[0] = b_lo;
                     we[1] = 1'b1;
                     wa[1] = a2;
                     wd[1] = a_lo;
                     we[2] = wide;
                     wa[2] = a1p;
                     wd[2] = b_hi;
                     we[3] = wide;
                     wa[3] = a2p;
                     wd[3] = a_hi;
                  end
               end
               OP_BIN2BCD:
               begin
                  if (bcd_range_bad)
                  begin
                     set_err = 1'b1;
                  end
                  else
                  begin
                     we[0] = 1'b1;
                     wa[0] = ad;
                     wd[0] = bcd_res[15:0];
                     we[1] = wide;
                     wa[1] = adp;
                     wd[1] = bcd_res[31:16];
                  end
               end
               OP_BCD2BIN:
               begin
                  if (bcd_digit_bad)
                  begin
                     set_err = 1'b1;
                  end
                  else
                  begin
                     we[0] = 1'b1;
                     wa[0] = ad;
                     wd[0] = bin_res[15:0];
                     we[1] = wide;
                     wa[1] = adp;
                     wd[1] = bin_res[31:16];
                  end
               end
               OP_ADD:
               begin
                  // Only the destination words are written; sources stay as they were unless a destination word overlaps them
                  we[0] = 1'b1;
                  wa[0] = ad;
                  wd[0] = sum_wrap[15:0];
                  we[1] = wide;
                  wa[1] = adp;
                  wd[1] = sum_wrap[31:16];
                  next_zero = add_zero;
                  next_borrow = add_borrow;
                  next_carry = add_carry;
               end
            endcase
         end
      end
      // Hardware set wins over a software clear in the same cycle
      if (set_err)
      begin
         next_err_a = 1'b1;
         next_err_b = 1'b1;
         next_errc = ERR_RANGE_CODE;
      end
      next_irq_stat = next_irq_stat | {set_rej, set_err, set_done};
      next_irq = |(next_irq_stat & next_irq_mask);
      next_prdata = '0;
      if (apb_setup && !PWRITE)
      begin
         case (PADDR)
            REG_CTRL: next_prdata = 32'(ctrl);
            REG_OPER: next_prdata = {8'h00, oper};
            REG_STATUS: next_prdata = {27'h0, operation_error_flag_b, operation_error_flag_a,
               carry_flag, borrow_flag, zero_result_flag};
            REG_ERRC: next_prdata = {16'h0000, errc};
            REG_IRQ_STAT: next_prdata = 32'(irq_stat);
            REG_IRQ_MASK: next_prdata = 32'(irq_mask);
            REG_MEM_PTR: next_prdata = 32'(mem_ptr);
            REG_MEM_DATA: next_prdata = {16'h0000, mem[mem_ptr]};
            default: next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ctrl <= CTRL_RST;
         oper <= OPER_RST;
         errc <= ERRC_RST;
         zero_result_flag <= 1'b0;
         borrow_flag <= 1'b0;
         carry_flag <= 1'b0;
         operation_error_flag_a <= 1'b0;
         operation_error_flag_b <= 1'b0;
         irq_stat <= IRQ_RST;
         irq_mask <= IRQ_RST;
         mem_ptr <= '0;
         en_q <= 1'b0;
         PRDATA <= '0;
         IRQ <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         oper <= next_oper;
         errc <= next_errc;
         zero_result_flag <= next_zero;
         borrow_flag <= next_borrow;
         carry_flag <= next_carry;
         operation_error_flag_a <= next_err_a;
         operation_error_flag_b <= next_err_b;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         mem_ptr <= next_mem_ptr;
         en_q <= next_en_q;
         PRDATA <= next_prdata;
         IRQ <= next_irq;
      end
   end

   // Later slots win when two slots name the same word
   always_ff @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < MEM_DEPTH; i++)
         begin
            mem[i] <= '0;
         end
      end
      else
      begin
         for (int s = 0; s < 5; s++)
         begin
            if (we[s])
            begin
               mem[wa[s]] <= wd[s];
            end
         end
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   a_exch_swap: assert property (exec_go && !reject && op == OP_EXCH
      && !same_op && !wide && a2 != a1p
      |=> mem[$past(a1)] == $past(b_lo) && mem[$past(a2)] == $past(a_lo))
      else $error("exchange did not swap operands");
   a_idx_reject: assert property (exec_go && indexed && wide
      |-> !we[0] ##1 irq_stat[IRQ_REJ])
      else $error("indexed wide form was not refused");
   a_half_swap: assert property (exec_go && !reject && op == OP_EXCH
      && same_op && hswap
      |=> mem[$past(a1)] == $past(a_hi) && mem[$past(a1p)] == $past(a_lo))
      else $error("half swap wrong");
   a_bcd_range: assert property (exec_go && !reject && op == OP_BIN2BCD
      && bcd_range_bad
      |=> operation_error_flag_a && operation_error_flag_b && errc == 16'h0e18)
      else $error("range error not reported");
   a_bcd_digit: assert property (exec_go && !reject && op == OP_BCD2BIN
      && bcd_digit_bad
      |-> !we[0] ##1 (operation_error_flag_a && operation_error_flag_b && errc == 16'h0e18))
      else $error("bad digit not reported");
   a_add_carry: assert property (exec_go && !reject && op == OP_ADD && !wide
      |=> carry_flag == ($past(sum) > 33'sd32767)
      && borrow_flag == ($past(sum) < -33'sd32768))
      else $error("16-bit carry or borrow wrong");
   a_add_zero: assert property (exec_go && !reject && op == OP_ADD && wide
      |=> zero_result_flag == ($past(sum_wrap) == 32'h0))
      else $error("zero flag wrong");
   a_add_wrap: assert property (exec_go && !reject && op == OP_ADD && !wide
      && ad != a1 && ad != a2
      |=> mem[$past(ad)] == $past(a_lo + b_lo) && mem[$past(a1)] == $past(a_lo))
      else $error("sum not wrapped or source changed");
   a_pulse_once: assert property (ctrl[CTRL_PULSE] && en && $past(en) && $stable(ctrl)
      && !$past(apb_mem_wr) |-> !fire)
      else $error("pulse form fired twice");
   a_irq_level: assert property (|(irq_stat & irq_mask) |=> IRQ || $changed(irq_stat)
      || $changed(irq_mask))
      else $error("interrupt missing");

   c_exch_wide: cover property (exec_go && op == OP_EXCH && wide && !reject);
   c_bcd_err: cover property (exec_go && op == OP_BIN2BCD && bcd_range_bad);
   c_add_carry: cover property (exec_go && op == OP_ADD && add_carry);
   c_stall: cover property (fire && apb_mem_wr);
endmodule

// ==== tb_xbd_exchange_bcd_add.sv ====
/*
 Self-checking testbench of the exchange / BCD / add datapath, driven over APB.
 Assumes the design's own assertions stand inside its files; no separate checker.
*/
`timescale 1ns/10ps
module tb_xbd_exchange_bcd_add;
   import xbd_pkg::*;
   localparam logic [7:0] OA = 8'h10;
   localparam logic [7:0] OB = 8'h20;
   localparam logic [7:0] OD = 8'h30;
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rnd, v, t;
   logic [3:0] pstrb;
   logic e;
   int num_errors, compares;

   xbd_exchange_bcd_add #(.MEM_DEPTH(256)) i_xbd_exchange_bcd_add (.REF_CLK(ref_clk),
      .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .IRQ(irq));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction

   function automatic logic [31:0] to_bcd(input logic [31:0] b);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 8; i++)
      begin
         r[4*i +: 4] = 4'(b % 10);
         b = b / 10;
      end
      return r;
   endfunction

   // Result in [31:0], then zero, borrow, carry in [34:32] as the status bits lie
   function automatic logic [35:0] add_exp(input logic w, input logic [31:0] a, b);
      logic signed [33:0] s;
      logic [31:0] r;
      if (w)
         s = $signed({{2{a[31]}}, a}) + $signed({{2{b[31]}}, b});
      else
         s = $signed({{18{a[15]}}, a[15:0]}) + $signed({{18{b[15]}}, b[15:0]});
      r = w ? s[31:0] : {16'h5a5a, s[15:0]};
      return {1'b0, w ? (s > 34'sd2147483647) : (s > 34'sd32767),
              w ? (s < -34'sd2147483648) : (s < -34'sd32768),
              w ? (r == 32'h0) : (r[15:0] == 16'h0), r};
   endfunction

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      logic err;
      xfer(1'b0, a, 32'h0, d, err);
   endtask

   task automatic put32(input logic [7:0] a, input logic [31:0] d);
      wr(REG_MEM_PTR, {24'h0, a});
      wr(REG_MEM_DATA, {16'h0, d[15:0]});
      wr(REG_MEM_PTR, {24'h0, a + 8'h1});
      wr(REG_MEM_DATA, {16'h0, d[31:16]});
   endtask

   task automatic get32(input logic [7:0] a, output logic [31:0] d);
      logic [31:0] r;
      wr(REG_MEM_PTR, {24'h0, a});
      rd_reg(REG_MEM_DATA, r);
      d[15:0] = r[15:0];
      wr(REG_MEM_PTR, {24'h0, a + 8'h1});
      rd_reg(REG_MEM_DATA, r);
      d[31:16] = r[15:0];
   endtask

   // Enable held for several cycles: a pulse form must still run only once
   task automatic run(input xbd_op_t op, input logic w, p, ix, hs, input logic [7:0] a, b, d);
      logic [31:0] c;
      c = {25'h0, 1'b0, hs, ix, p, w, op};
      wr(REG_OPER, {8'h0, d, b, a});
      c[CTRL_EN] = 1'b1;
      wr(REG_CTRL, c);
      repeat (4) @(posedge ref_clk);
      c[CTRL_EN] = 1'b0;
      wr(REG_CTRL, c);
   endtask

   task automatic conv(input xbd_op_t op, input logic w, input logic [31:0] src, ok, res);
      logic [31:0] r;
      logic [31:0] x;
      wr(REG_STATUS, 32'h18);
      wr(REG_ERRC, 32'h0);
      put32(OA, w ? src : {16'h0, src[15:0]});
      put32(OD, 32'h5a5a5a5a);
      run(op, w, 1'b1, 1'b0, 1'b0, OA, OB, OD);
      get32(OD, r);
      x = w ? res : {16'h5a5a, res[15:0]};
      check("convert dest", ok[0] ? x : 32'h5a5a5a5a, r);
      rd_reg(REG_STATUS, r);
      check("error flags", ok[0] ? 32'h0 : 32'h3, {30'h0, r[4:3]});
      rd_reg(REG_ERRC, r);
      check("error code", ok[0] ? 32'h0 : {16'h0, ERR_RANGE_CODE}, r);
   endtask

   task automatic add_case(input logic w, p, input logic [31:0] a, b);
      logic [35:0] x;
      logic [31:0] r;
      x = add_exp(w, a, b);
      put32(OA, a);
      put32(OB, b);
      put32(OD, 32'h5a5a5a5a);
      run(OP_ADD, w, p, 1'b0, 1'b0, OA, OB, OD);
      get32(OD, r);
      check("sum", x[31:0], r);
      get32(OA, r);
      check("augend kept", a, r);
      get32(OB, r);
      check("addend kept", b, r);
      rd_reg(REG_STATUS, r);
      check("add flags", {29'h0, x[34:32]}, {29'h0, r[2:0]});
   endtask

   initial
   begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      end_sim();
   end

   initial
   begin
      sys_rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      num_errors = 0;
      compares = 0;
      rnd = 32'had040c12;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         rd_reg(8'(4 * i), v);
         check("reset value", 32'h0, v);
      end
      xfer(1'b0, 8'h20, 32'h0, v, e);
      check("unmapped error", 32'h1, {31'h0, e});
      check("unmapped data", 32'h0, v);
      // Exchange: 16-bit, 32-bit, indexed 16-bit, then indexed 32-bit refused
      for (int k = 0; k < 3; k++)
      begin
         rnd = lfsr_next(rnd);
         t = lfsr_next(rnd);
         put32(OA, rnd);
         put32(OB, t);
         run(OP_EXCH, k == 1, 1'b1, k == 2, 1'b0, OA, OB, OD);
         get32(OA, v);
         check("exchange first", k == 1 ? t : {rnd[31:16], t[15:0]}, v);
         get32(OB, v);
         check("exchange second", k == 1 ? rnd : {t[31:16], rnd[15:0]}, v);
      end
      wr(REG_IRQ_STAT, 32'h7);
      put32(OA, 32'h11112222);
      put32(OB, 32'h33334444);
      run(OP_EXCH, 1'b1, 1'b1, 1'b1, 1'b0, OA, OB, OD);
      get32(OA, v);
      check("refused exchange", 32'h11112222, v);
      rd_reg(REG_IRQ_STAT, v);
      check("refused status", 32'h5, {29'h0, v[2:0]});
      put32(OA, 32'h1234abcd);
      run(OP_EXCH, 1'b0, 1'b1, 1'b0, 1'b1, OA, OA, OD);
      get32(OA, v);
      check("half swap", 32'habcd1234, v);
      // Conversions with boundary and random values
      conv(OP_BIN2BCD, 1'b0, 32'd0, 1, 32'h0);
      conv(OP_BIN2BCD, 1'b0, 32'd9999, 1, 32'h9999);
      conv(OP_BIN2BCD, 1'b0, 32'd10000, 0, 32'h0);
      conv(OP_BIN2BCD, 1'b0, 32'hffff, 0, 32'h0);
      conv(OP_BIN2BCD, 1'b1, 32'd99999999, 1, 32'h99999999);
      conv(OP_BIN2BCD, 1'b1, 32'd100000000, 0, 32'h0);
      conv(OP_BCD2BIN, 1'b0, 32'h9999, 1, 32'd9999);
      conv(OP_BCD2BIN, 1'b0, 32'h00a0, 0, 32'h0);
      conv(OP_BCD2BIN, 1'b1, 32'h99999999, 1, 32'd99999999);
      conv(OP_BCD2BIN, 1'b1, 32'h1234567a, 0, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
         rnd = lfsr_next(rnd);
         t = k[0] ? rnd % 100000000 : rnd % 10000;
         conv(OP_BIN2BCD, k[0], t, 1, to_bcd(t));
         conv(OP_BCD2BIN, k[0], to_bcd(t), 1, t);
      end
      // Addition: overflow, underflow and zero corners, then random operands
      add_case(1'b0, 1'b1, 32'h00007fff, 32'h00000001);
      add_case(1'b0, 1'b1, 32'h00008000, 32'h0000ffff);
      add_case(1'b0, 1'b1, 32'h00000003, 32'h0000fff7);
      add_case(1'b0, 1'b1, 32'h00000005, 32'h0000fffb);
      add_case(1'b1, 1'b1, 32'h7fffffff, 32'h00000001);
      add_case(1'b1, 1'b1, 32'h80000000, 32'hffffffff);
      add_case(1'b1, 1'b1, 32'h00010000, 32'hffff0000);
      for (int k = 0; k < 8; k++)
      begin
         rnd = lfsr_next(rnd);
         t = lfsr_next(rnd);
         add_case(k[0], 1'b1, rnd, t);
      end
      // Pulse form adds once into its own source, plain form every enabled cycle
      put32(OA, 32'h5);
      put32(OB, 32'h1);
      run(OP_ADD, 1'b0, 1'b1, 1'b0, 1'b0, OA, OB, OA);
      get32(OA, v);
      check("pulse once", 32'h6, {16'h0, v[15:0]});
      put32(OA, 32'h5);
      run(OP_ADD, 1'b0, 1'b0, 1'b0, 1'b0, OA, OB, OA);
      get32(OA, v);
      check("plain repeats", 32'h1, {31'h0, v[15:0] > 16'd6});
      // Interrupt: raised, masked, unmasked, cleared, then on an error
      wr(REG_IRQ_STAT, 32'h7);
      wr(REG_IRQ_MASK, 32'h1);
      run(OP_ADD, 1'b0, 1'b1, 1'b0, 1'b0, OA, OB, OD);
      check("irq raised", 32'h1, {31'h0, irq});
      wr(REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(REG_IRQ_MASK, 32'h1);
      repeat (2) @(posedge ref_clk);
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr(REG_IRQ_STAT, 32'h7);
      repeat (2) @(posedge ref_clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      wr(REG_IRQ_MASK, 32'h2);
      conv(OP_BCD2BIN, 1'b0, 32'h00f0, 0, 32'h0);
      check("irq on error", 32'h1, {31'h0, irq});
      end_sim();
   end
endmodule
